// File: verilog/mirq_core.sv
// Interrupt masks, internal temperature offset and reading registers
//
// Operation
// - Misc mask bit 0 set blocks on-chip temperature interrupts.
// - Misc mask bit 1 set blocks battery voltage interrupts.
// - Misc mask bit 2 set blocks analog input 8 interrupts.
// - Misc mask bit 3 set blocks thermal-limit alarm interrupts.
// - Misc mask bit 4 set blocks automatic fan control interrupts.
// - Misc mask bit 5 has no function and always reads zero.
// - Misc mask bit 6 set blocks chassis intrusion interrupts.
// - Misc mask bit 7 set blocks general I/O channel 16 interrupts.
// - Low GPIO mask bit n blocks general I/O channel n.
// - High GPIO mask bit n blocks general I/O channel n plus 8.
// - All three mask registers clear to zero at reset.
// - Signed offset added to each temperature result before storing and comparing.
// - Latest temperature readable in read-only register, zero after reset.
module mirq_core
    import mirq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic temp_valid,
    input wire logic [7:0] temp_raw,
    output logic temp_store,
    output logic [7:0] temp_compare,
    input wire logic int_temp_event,
    input wire logic battery_event,
    input wire logic analog_input_8_event,
    input wire logic thermal_limit_alarm,
    input wire logic auto_fan_speed_control,
    input wire logic chassis_intrusion_input,
    input wire logic general_io_channel_16,
    input wire logic [7:0] general_io_channels_low,
    input wire logic [7:0] general_io_channels_high,
    output logic [16:0] gpio_irq_req,
    output logic [6:0] misc_irq_req
);
    import mirq_pkg::*;

    logic [7:0] mask_misc_r;
    logic [7:0] mask_gpio_low_r;
    logic [7:0] mask_gpio_high_r;
    logic [7:0] temp_offset_r;
    logic [7:0] temp_reading_r;
    logic [7:0] temp_sum_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] misc_src;
    logic [7:0] misc_gated;

    // Signed add clipped to the 8-bit range, never wrapping
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {a[7], a} + {b[7], b};
        if (s[8] != s[7]) begin
            sat_add = s[8] ? MIRQ_S8_MIN : MIRQ_S8_MAX;
        end else begin
            sat_add = s[7:0];
        end
    endfunction

    // Write strobe aimed at one register offset in this cycle
    function automatic logic wr_hit(input logic en, input logic wr, input logic [7:0] addr,
        input logic [7:0] off);
        wr_hit = en && wr && (addr == off);
    endfunction

    // A request survives only while its mask bit is clear
    function automatic logic [7:0] gate(input logic [7:0] src, input logic [7:0] msk);
        gate = src & ~msk;
    endfunction

    // Sources laid out in the same bit order as the misc mask
    assign misc_src[MIRQ_BIT_INT_TEMP] = int_temp_event;
    assign misc_src[MIRQ_BIT_BATTERY] = battery_event;
    assign misc_src[MIRQ_BIT_ANALOG_INPUT_8] = analog_input_8_event;
    assign misc_src[MIRQ_BIT_THERMAL] = thermal_limit_alarm;
    assign misc_src[MIRQ_BIT_FAN_CTRL] = auto_fan_speed_control;
    assign misc_src[MIRQ_BIT_UNUSED] = 1'b0;
    assign misc_src[MIRQ_BIT_CHASSIS] = chassis_intrusion_input;
    assign misc_src[MIRQ_BIT_GPIO_16] = general_io_channel_16;
    assign misc_gated = gate(misc_src, mask_misc_r);

    assign temp_sum_nxt = sat_add(temp_raw, temp_offset_r);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_misc_r <= MIRQ_RST_MASK;
        end else if (wr_hit(clk_en, reg_wr, reg_addr, MIRQ_OFF_MASK_MISC)) begin
            // Unused bit never stored, so no read can show it
            mask_misc_r <= reg_wdata & MIRQ_MISC_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_gpio_low_r <= MIRQ_RST_MASK;
        end else if (wr_hit(clk_en, reg_wr, reg_addr, MIRQ_OFF_MASK_GPIO_LOW)) begin
            mask_gpio_low_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_gpio_high_r <= MIRQ_RST_MASK;
        end else if (wr_hit(clk_en, reg_wr, reg_addr, MIRQ_OFF_MASK_GPIO_HIGH)) begin
            mask_gpio_high_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_offset_r <= MIRQ_RST_OFFSET;
        end else if (wr_hit(clk_en, reg_wr, reg_addr, MIRQ_OFF_TEMP_OFFSET)) begin
            temp_offset_r <= reg_wdata;
        end
    end

    // Reading register is read-only: writes to it fall through every decode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_reading_r <= MIRQ_RST_READING;
        end else if (clk_en && temp_valid) begin
            temp_reading_r <= temp_sum_nxt;
        end
    end

    // Limit logic sees the same corrected value that the host reads back
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_compare <= MIRQ_RST_READING;
        end else if (clk_en && temp_valid) begin
            temp_compare <= temp_sum_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_store <= 1'b0;
        end else if (clk_en) begin
            temp_store <= temp_valid;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            MIRQ_OFF_MASK_MISC: rdata_nxt = mask_misc_r & MIRQ_MISC_WMASK;
            MIRQ_OFF_MASK_GPIO_LOW: rdata_nxt = mask_gpio_low_r;
            MIRQ_OFF_MASK_GPIO_HIGH: rdata_nxt = mask_gpio_high_r;
            MIRQ_OFF_TEMP_OFFSET: rdata_nxt = temp_offset_r;
            MIRQ_OFF_TEMP_READING: rdata_nxt = temp_reading_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Masks gate only the requests; event inputs keep feeding status elsewhere
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            misc_irq_req <= 7'h00;
        end else if (clk_en) begin
            misc_irq_req[0] <= misc_gated[MIRQ_BIT_INT_TEMP];
            misc_irq_req[1] <= misc_gated[MIRQ_BIT_BATTERY];
            misc_irq_req[2] <= misc_gated[MIRQ_BIT_ANALOG_INPUT_8];
            misc_irq_req[3] <= misc_gated[MIRQ_BIT_THERMAL];
            misc_irq_req[4] <= misc_gated[MIRQ_BIT_FAN_CTRL];
            misc_irq_req[5] <= misc_gated[MIRQ_BIT_CHASSIS];
            misc_irq_req[6] <= misc_gated[MIRQ_BIT_GPIO_16];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_irq_req[7:0] <= 8'h00;
        end else if (clk_en) begin
            gpio_irq_req[7:0] <= gate(general_io_channels_low, mask_gpio_low_r);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_irq_req[15:8] <= 8'h00;
        end else if (clk_en) begin
            gpio_irq_req[15:8] <= gate(general_io_channels_high, mask_gpio_high_r);
        end
    end

    // Channel 16 has its mask bit in the misc register, not a GPIO one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_irq_req[16] <= 1'b0;
        end else if (clk_en) begin
            gpio_irq_req[16] <= misc_gated[MIRQ_BIT_GPIO_16];
        end
    end
endmodule

// File: verilog/mirq_pkg.sv
// Register map, field positions and reset values for the mask and temperature slice
package mirq_pkg;
    localparam logic [7:0] MIRQ_OFF_MASK_MISC = 8'h1b;
    localparam logic [7:0] MIRQ_OFF_MASK_GPIO_LOW = 8'h1c;
    localparam logic [7:0] MIRQ_OFF_MASK_GPIO_HIGH = 8'h1d;
    localparam logic [7:0] MIRQ_OFF_TEMP_OFFSET = 8'h1e;
    localparam logic [7:0] MIRQ_OFF_TEMP_READING = 8'h1f;
    localparam logic [7:0] MIRQ_RST_MASK = 8'h00;
    localparam logic [7:0] MIRQ_RST_OFFSET = 8'h00;
    localparam logic [7:0] MIRQ_RST_READING = 8'h00;
    localparam int MIRQ_BIT_INT_TEMP = 0;
    localparam int MIRQ_BIT_BATTERY = 1;
    localparam int MIRQ_BIT_ANALOG_INPUT_8 = 2;
    localparam int MIRQ_BIT_THERMAL = 3;
    localparam int MIRQ_BIT_FAN_CTRL = 4;
    localparam int MIRQ_BIT_UNUSED = 5;
    localparam int MIRQ_BIT_CHASSIS = 6;
    localparam int MIRQ_BIT_GPIO_16 = 7;
    localparam logic [7:0] MIRQ_MISC_WMASK = 8'hdf;
    localparam logic [7:0] MIRQ_S8_MAX = 8'h7f;
    localparam logic [7:0] MIRQ_S8_MIN = 8'h80;
endpackage

// File: tb/mirq_core_asserts.sv
// Port checks for the mask and temperature slice
module mirq_core_asserts (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic reg_rd,
    input wire logic temp_valid,
    input wire logic temp_store,
    input wire logic int_temp_event,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] temp_raw,
    input wire logic [7:0] temp_compare,
    input wire logic [7:0] general_io_channels_low,
    input wire logic [6:0] misc_irq_req,
    input wire logic [16:0] gpio_irq_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_store_follows: assert property (clk_en && temp_valid |=> temp_store)
        else $error("store pulse missing");
    a_store_quiet: assert property (clk_en && !temp_valid |=> !temp_store)
        else $error("stray store pulse");
    a_bit5_zero: assert property (clk_en && reg_rd && reg_addr == 8'h1b |=> !reg_rdata[5])
        else $error("unused mask bit reads one");
    a_unmapped_zero: assert property (clk_en && reg_rd && reg_addr > 8'h1f |=> reg_rdata == 0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_reading_match: assert property (clk_en && reg_rd && reg_addr == 8'h1f
        |=> reg_rdata == $past(temp_compare)) else $error("reading differs from compare");
    a_general_io_channel_16_twin: assert property (gpio_irq_req[16] == misc_irq_req[6])
        else $error("channel 16 requests disagree");
    a_gpio_quiet: assert property (clk_en && general_io_channels_low == 0
        |=> gpio_irq_req[7:0] == 0) else $error("request without source");
    a_temp_quiet: assert property (clk_en && !int_temp_event |=> !misc_irq_req[0])
        else $error("temperature request without source");
    a_sat_floor: assert property (clk_en && temp_valid && temp_raw == 8'h80
        |=> temp_compare[7]) else $error("offset wrapped past minimum");
endmodule
bind mirq_core mirq_core_asserts mirq_core_asserts_i (.*);

// File: tb/mirq_host.sv
// Host side register access model
module mirq_host (
    input wire logic ref_clk,
    output logic reg_wr, reg_rd,
    output logic [7:0] reg_addr, reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    // One byte per access; released data shows its inverse
    task acc(input logic w, input logic [7:0] a, d);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_wdata} <= {2'b00, ~d};
    endtask
endmodule

// File: tb/test_monitor_irq_mask_and_temp_offset.sv
// Testbench for the mask and temperature slice
module test_monitor_irq_mask_and_temp_offset;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, nrst, clk_en, reg_wr, reg_rd, temp_valid, temp_store;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_raw, temp_compare;
    logic [6:0] ms, misc_irq_req;
    logic [15:0] gs;
    logic [16:0] gpio_irq_req;
    int bad_count, checks;
    logic [7:0] rows [6][3] = '{'{8'h1b, 8'hff, 8'hdf}, '{8'h1c, 8'ha5, 8'ha5},
        '{8'h1d, 8'h5a, 8'h5a}, '{8'h1e, 8'h03, 8'h03}, '{8'h1f, 8'h55, 8'h00},
        '{8'h20, 8'hff, 8'h00}};
    mirq_host mirq_host_i (.*);
    mirq_core mirq_core_i (.*, .clk_en(clk_en), .int_temp_event(ms[0]), .battery_event(ms[1]),
        .analog_input_8_event(ms[2]), .thermal_limit_alarm(ms[3]),
        .auto_fan_speed_control(ms[4]), .chassis_intrusion_input(ms[5]),
        .general_io_channel_16(ms[6]), .general_io_channels_low(gs[7:0]),
        .general_io_channels_high(gs[15:8]));
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    task cmp(input logic [16:0] g, e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task rdc(input logic [7:0] a, e);
        mirq_host_i.acc(1'b0, a, 8'h00);
        #1 cmp(17'(reg_rdata), 17'(e));
    endtask
    task tmp(input logic [7:0] raw, e);
        @(posedge ref_clk);
        {temp_valid, temp_raw} <= {1'b1, raw};
        @(posedge ref_clk);
        {temp_valid, temp_raw} <= {1'b0, ~raw};
        #1 cmp(17'(temp_store), 17'h1);
        cmp(17'(temp_compare), 17'(e));
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {nrst, temp_valid, temp_raw, ms, gs, bad_count, checks} = '0;
        clk_en = 1'b1;
        repeat (20) @(posedge ref_clk);
        nrst <= 1;
        foreach (rows[i]) begin
            rdc(rows[i][0], 8'h00);
            mirq_host_i.acc(1'b1, rows[i][0], rows[i][1]);
            rdc(rows[i][0], rows[i][2]);
        end
        $display("register table done");
        tmp(8'h10, 8'h13);
        rdc(8'h1f, 8'h13);
        tmp(8'h7e, 8'h7f);
        mirq_host_i.acc(1'b1, 8'h1e, 8'h80);
        tmp(8'h80, 8'h80);
        $display("temperature done");
        mirq_host_i.acc(1'b1, 8'h1b, 8'h0a);
        {ms, gs} <= {7'h7f, 16'hffff};
        repeat (2) @(posedge ref_clk);
        #1 cmp(17'(misc_irq_req), 17'h75);
        cmp(gpio_irq_req, 17'h1a55a);
        mirq_host_i.acc(1'b1, 8'h1b, 8'hf5);
        repeat (2) @(posedge ref_clk);
        #1 cmp(17'(misc_irq_req), 17'h0a);
        cmp(gpio_irq_req, 17'h0a55a);
        $display("masking done");
        @(posedge ref_clk);
        clk_en <= 1'b0;
        mirq_host_i.acc(1'b1, 8'h1c, 8'hff);
        clk_en <= 1'b1;
        rdc(8'h1c, 8'ha5);
        $display("freeze done");
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 cmp(17'(misc_irq_req), 17'h00);
        cmp(gpio_irq_req, 17'h00000);
        cmp(17'(reg_rdata), 17'h00);
        @(posedge ref_clk);
        nrst <= 1'b1;
        rdc(8'h1b, 8'h00);
        rdc(8'h1d, 8'h00);
        rdc(8'h1f, 8'h00);
        $display("reset done");
        end_sim;
    end
endmodule
